/* hw/network_status_led_patterns.sv */
// front panel led pattern generator for the tcp and controlled-node profiles
`timescale 1ns/1ns
module network_status_led_patterns #(
	parameter int P_PORTS = 2,
	parameter int P_TICK_CYCLES = net_led_pkg::TICK_CYCLES
) (
	// clock and reset
	input logic i_clk_sys,
	input logic i_rst_n,

	// profile select, held static
	input logic i_profile,

	// tcp protocol task state
	input logic i_task_ready,
	input logic i_task_configured,
	input logic i_task_connected,
	input logic i_sys_error,
	input logic i_comm_error,

	// controlled-node state
	input net_led_pkg::cn_state_e i_cn_state,
	input logic i_cn_error,

	// ethernet ports
	input logic [P_PORTS-1:0] i_link,
	input logic [P_PORTS-1:0] i_frame,

	// status duo led (run / bus state)
	output logic o_status_green,
	output logic o_status_red,

	// fault led (error / bus fault)
	output logic o_fault_red,

	// per port leds
	output logic [P_PORTS-1:0] o_port_green,
	output logic [P_PORTS-1:0] o_port_yellow
);
	import net_led_pkg::*;

	// ======================================================================
	// declarations

	localparam int TICK_W = (P_TICK_CYCLES > 1) ? $clog2(P_TICK_CYCLES) : 1;

	logic [TICK_W-1:0] tick_cnt_ff;
	logic [TICK_W-1:0] nxt_tick_cnt;
	logic tick_ff;
	logic tick_last;

	stat_pat_e tcp_run_pat;
	stat_pat_e cn_bus_pat;
	stat_pat_e stat_pat_sel;
	stat_pat_e stat_pat_ff;
	logic stat_restart;
	phase_t stat_period;
	phase_t stat_phase_ff;
	phase_t nxt_stat_phase;
	logic stat_wrap;

	err_pat_e tcp_err_pat;
	err_pat_e cn_err_pat;
	err_pat_e err_pat_sel;
	err_pat_e err_pat_ff;
	logic err_restart;
	phase_t err_phase_ff;
	phase_t nxt_err_phase;
	logic err_wrap;

	logic in_pulse1;
	logic in_pulse2;
	logic in_pulse3;
	logic nxt_status_green;
	logic nxt_status_red;
	logic nxt_fault_red;

	logic [P_PORTS-1:0] act_lit;
	logic [P_PORTS-1:0] nxt_port_green;
	logic [P_PORTS-1:0] nxt_port_yellow;

	logic status_green_ff;
	logic status_red_ff;
	logic fault_red_ff;
	logic [P_PORTS-1:0] port_green_ff;
	logic [P_PORTS-1:0] port_yellow_ff;

	// ======================================================================
	// millisecond tick

	// divider from the system clock
	assign tick_last = (tick_cnt_ff == TICK_W'(P_TICK_CYCLES - 1));
	assign nxt_tick_cnt = tick_last ? '0 : TICK_W'(tick_cnt_ff + 1'h1); // RULE22

	// one cycle pulse per millisecond
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'h0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff <= tick_last;
		end
	end

	// ======================================================================
	// status led pattern selection

	// tcp run led: not ready wins, then connected, configured, ready
	assign tcp_run_pat = !i_task_ready ? PAT_OFF : // RULE4
		i_task_connected ? PAT_ON : // RULE1
		i_task_configured ? PAT_FAST : // RULE3
		PAT_SLOW; // RULE2

	// node bus state led by node state
	assign cn_bus_pat = (i_cn_state == CN_OPER) ? PAT_ON : // RULE11
		(i_cn_state == CN_READY) ? PAT_TRIPLE : // RULE11
		(i_cn_state == CN_PREOP2) ? PAT_DOUBLE : // RULE11
		(i_cn_state == CN_PREOP1) ? PAT_SINGLE : // RULE11
		(i_cn_state == CN_BASIC_ETH) ? PAT_FLICK_ALT : // RULE12
		(i_cn_state == CN_STOPPED) ? PAT_BLINK_ALT : // RULE13
		PAT_OFF; // RULE11

	// profile mux
	assign stat_pat_sel = (i_profile == PROFILE_CN) ? cn_bus_pat : tcp_run_pat; // RULE21

	// ======================================================================
	// status led phase counter

	// period of the running pattern in ms
	assign stat_period = (stat_pat_ff == PAT_SLOW) ? SLOW_PERIOD : // RULE6
		(stat_pat_ff == PAT_FAST) ? FAST_PERIOD : // RULE7
		(stat_pat_ff == PAT_TRIPLE) ? TRIPLE_PERIOD : // RULE14
		(stat_pat_ff == PAT_DOUBLE) ? DOUBLE_PERIOD : // RULE15
		(stat_pat_ff == PAT_SINGLE) ? SINGLE_PERIOD : // RULE16
		(stat_pat_ff == PAT_FLICK_ALT) ? FLICK_PERIOD : // RULE17
		(stat_pat_ff == PAT_BLINK_ALT) ? BLINK_PERIOD : // RULE13
		IDLE_PERIOD;

	// a new pattern always starts at its first lit phase
	assign stat_restart = (stat_pat_sel != stat_pat_ff);
	assign stat_wrap = (stat_phase_ff >= stat_period - 12'h001);
	assign nxt_stat_phase = stat_restart ? 12'h000 : // RULE22
		!tick_ff ? stat_phase_ff :
		stat_wrap ? 12'h000 :
		phase_t'(stat_phase_ff + 12'h001);

	// pattern and phase registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			stat_pat_ff <= PAT_OFF;
			stat_phase_ff <= 12'h000;
		end else begin
			stat_pat_ff <= stat_pat_sel;
			stat_phase_ff <= nxt_stat_phase;
		end
	end

	// ======================================================================
	// status led decode

	// flash windows: lit 200 ms, dark 200 ms between pulses
	assign in_pulse1 = (stat_phase_ff < T_FLASH_MS);
	assign in_pulse2 = (stat_phase_ff >= phase_t'(T_FLASH_MS * 2)) &&
		(stat_phase_ff < phase_t'(T_FLASH_MS * 3));
	assign in_pulse3 = (stat_phase_ff >= phase_t'(T_FLASH_MS * 4)) &&
		(stat_phase_ff < phase_t'(T_FLASH_MS * 5));

	// green element
	assign nxt_status_green =
		(stat_pat_ff == PAT_ON) || // RULE1
		((stat_pat_ff == PAT_SLOW) && (stat_phase_ff < T_SLOW_MS)) || // RULE6
		((stat_pat_ff == PAT_FAST) && (stat_phase_ff < T_FAST_MS)) || // RULE7
		((stat_pat_ff == PAT_TRIPLE) && (in_pulse1 || in_pulse2 || in_pulse3)) || // RULE14
		((stat_pat_ff == PAT_DOUBLE) && (in_pulse1 || in_pulse2)) || // RULE15
		((stat_pat_ff == PAT_SINGLE) && in_pulse1) || // RULE16
		((stat_pat_ff == PAT_FLICK_ALT) && (stat_phase_ff < T_FLICK_MS)) || // RULE17
		((stat_pat_ff == PAT_BLINK_ALT) && (stat_phase_ff < T_FLASH_MS)); // RULE13

	// red element takes the second half of the alternating patterns
	assign nxt_status_red =
		((stat_pat_ff == PAT_FLICK_ALT) && (stat_phase_ff >= T_FLICK_MS)) || // RULE17
		((stat_pat_ff == PAT_BLINK_ALT) && (stat_phase_ff >= T_FLASH_MS)); // RULE13

	// ======================================================================
	// fault led

	// tcp: a live communication error overrides the system error flash
	assign tcp_err_pat = i_comm_error ? ERR_ON : // RULE5
		i_sys_error ? ERR_FLASH : // RULE5
		ERR_OFF; // RULE5
	assign cn_err_pat = i_cn_error ? ERR_ON : ERR_OFF; // RULE18
	assign err_pat_sel = (i_profile == PROFILE_CN) ? cn_err_pat : tcp_err_pat; // RULE21

	// phase counter, restarted on change
	assign err_restart = (err_pat_sel != err_pat_ff);
	assign err_wrap = (err_phase_ff >= ERR_PERIOD - 12'h001);
	assign nxt_err_phase = err_restart ? 12'h000 : // RULE22
		!tick_ff ? err_phase_ff :
		err_wrap ? 12'h000 :
		phase_t'(err_phase_ff + 12'h001);

	// 125 ms lit then 375 ms dark
	assign nxt_fault_red = (err_pat_ff == ERR_ON) ||
		((err_pat_ff == ERR_FLASH) && (err_phase_ff < T_ERR_ON_MS)); // RULE5

	// pattern and phase registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			err_pat_ff <= ERR_OFF;
			err_phase_ff <= 12'h000;
		end else begin
			err_pat_ff <= err_pat_sel;
			err_phase_ff <= nxt_err_phase;
		end
	end

	// ======================================================================
	// port leds

	// one activity flicker per port
	for (genvar g = 0; g < P_PORTS; g++) begin : g_port
		port_traffic_indicator u_act (
			.i_clk_sys(i_clk_sys),
			.i_rst_n(i_rst_n),
			.i_tick_ms(tick_ff),
			.i_link(i_link[g]),
			.i_frame(i_frame[g]),
			.o_lit(act_lit[g])
		);
	end

	// tcp: green is link, yellow is activity
	// node: green is link, dark during flicker on phases; yellow unused
	assign nxt_port_green = (i_profile == PROFILE_CN) ?
		(i_link & ~act_lit) : // RULE19
		i_link; // RULE8
	assign nxt_port_yellow = (i_profile == PROFILE_CN) ?
		{P_PORTS{1'h0}} : // RULE20
		(act_lit & i_link); // RULE9

	// ======================================================================
	// output registers

	// every led off while reset is held
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			status_green_ff <= 1'h0; // RULE21
			status_red_ff <= 1'h0;
			fault_red_ff <= 1'h0;
			port_green_ff <= '0;
			port_yellow_ff <= '0;
		end else begin
			status_green_ff <= nxt_status_green;
			status_red_ff <= nxt_status_red;
			fault_red_ff <= nxt_fault_red;
			port_green_ff <= nxt_port_green;
			port_yellow_ff <= nxt_port_yellow;
		end
	end

	// outputs straight from flops
	assign o_status_green = status_green_ff;
	assign o_status_red = status_red_ff;
	assign o_fault_red = fault_red_ff;
	assign o_port_green = port_green_ff;
	assign o_port_yellow = port_yellow_ff;

endmodule

/* hw/net_led_pkg.sv */
// constants, encodings and timing for the network status led pattern block
// ==========================================================================
// Overview of operation
// [RULE1] tcp: run steady green when connected
// [RULE2] tcp: run 1 Hz while ready, unconfigured
// [RULE3] tcp: run 5 Hz once configured, waiting
// [RULE4] tcp: run dark while task not ready
// [RULE5] tcp: error off, 125/375 flash, steady
// [RULE6] 1 Hz pattern: 500 ms on, 500 off
// [RULE7] 5 Hz pattern: 100 ms on, 100 off
// [RULE8] tcp: link green follows port link
// [RULE9] tcp: yellow flickers with frames, else off
// [RULE10] flicker 50/50 ms heavy, per-frame when light
// [RULE11] node: bus state green per node state
// [RULE12] node: basic ethernet shows 10 Hz flicker
// [RULE13] node: stopped blinks 200/200 red-green alternating
// [RULE14] triple flash: three 200 ms, 1000 dark
// [RULE15] double flash: two 200 ms, 1000 dark
// [RULE16] single flash: one 200 ms, 1000 dark
// [RULE17] 10 Hz flicker 50/50, red-green alternating
// [RULE18] node: bus fault red steady on error
// [RULE19] node: link green steady, flickers, off
// [RULE20] node: yellow led always off
// [RULE21] static profile select; leds off in reset
// [RULE22] millisecond tick timing; restart on change
// ==========================================================================
package net_led_pkg;

	// ======================================================================
	// clock and tick
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ======================================================================
	// pattern times, counted in millisecond ticks
	typedef logic [11:0] phase_t;
	localparam phase_t T_SLOW_MS = 12'h1F4; // 500 ms
	localparam phase_t T_FAST_MS = 12'h064; // 100 ms
	localparam phase_t T_ERR_ON_MS = 12'h07D; // 125 ms
	localparam phase_t T_ERR_OFF_MS = 12'h177; // 375 ms
	localparam phase_t T_FLASH_MS = 12'h0C8; // 200 ms
	localparam phase_t T_LONG_OFF_MS = 12'h3E8; // 1000 ms
	localparam phase_t T_FLICK_MS = 12'h032; // 50 ms

	// derived periods
	localparam phase_t SLOW_PERIOD = phase_t'(T_SLOW_MS * 2);
	localparam phase_t FAST_PERIOD = phase_t'(T_FAST_MS * 2);
	localparam phase_t ERR_PERIOD = phase_t'(T_ERR_ON_MS + T_ERR_OFF_MS);
	localparam phase_t TRIPLE_PERIOD = phase_t'(T_FLASH_MS * 5 + T_LONG_OFF_MS);
	localparam phase_t DOUBLE_PERIOD = phase_t'(T_FLASH_MS * 3 + T_LONG_OFF_MS);
	localparam phase_t SINGLE_PERIOD = phase_t'(T_FLASH_MS + T_LONG_OFF_MS);
	localparam phase_t FLICK_PERIOD = phase_t'(T_FLICK_MS * 2);
	localparam phase_t BLINK_PERIOD = phase_t'(T_FLASH_MS * 2);
	localparam phase_t IDLE_PERIOD = 12'h001;

	// ======================================================================
	// profile select and node states
	localparam logic PROFILE_TCP = 1'h0;
	localparam logic PROFILE_CN = 1'h1;

	typedef enum logic [2:0] {
		CN_INIT = 3'h0,
		CN_PREOP1 = 3'h1,
		CN_PREOP2 = 3'h2,
		CN_READY = 3'h3,
		CN_OPER = 3'h4,
		CN_STOPPED = 3'h5,
		CN_BASIC_ETH = 3'h6
	} cn_state_e;

	// ======================================================================
	// pattern and activity encodings
	typedef enum logic [8:0] {
		PAT_OFF = 9'h001,
		PAT_ON = 9'h002,
		PAT_SLOW = 9'h004,
		PAT_FAST = 9'h008,
		PAT_TRIPLE = 9'h010,
		PAT_DOUBLE = 9'h020,
		PAT_SINGLE = 9'h040,
		PAT_FLICK_ALT = 9'h080,
		PAT_BLINK_ALT = 9'h100
	} stat_pat_e;

	typedef enum logic [2:0] {
		ERR_OFF = 3'h1,
		ERR_FLASH = 3'h2,
		ERR_ON = 3'h4
	} err_pat_e;

	typedef enum logic [2:0] {
		ACT_IDLE = 3'h1,
		ACT_ON = 3'h2,
		ACT_GAP = 3'h4
	} act_state_e;

endpackage

/* hw/port_traffic_indicator.sv */
// load dependent frame activity flicker for one ethernet port
`timescale 1ns/1ns
module port_traffic_indicator (
	// clock and reset
	input logic i_clk_sys,
	input logic i_rst_n,
	// timing
	input logic i_tick_ms,
	// port status
	input logic i_link,
	input logic i_frame,
	// indicator
	output logic o_lit
);
	import net_led_pkg::*;

	act_state_e state_ff;
	act_state_e nxt_state;
	phase_t hold_ff;
	phase_t nxt_hold;
	logic pend_ff;
	logic nxt_pend;
	logic lit_ff;
	logic hold_done;
	logic take;

	// a frame is remembered, the one that starts a flash too, so heavy load gives 50/50 and light load two flashes per frame
	assign hold_done = i_tick_ms && (hold_ff >= T_FLICK_MS - 12'h001);
	assign take = i_frame || pend_ff;
	assign nxt_state = !i_link ? ACT_IDLE :
		(state_ff == ACT_IDLE && take) ? ACT_ON : // RULE10
		(state_ff == ACT_ON && hold_done) ? ACT_GAP :
		(state_ff == ACT_GAP && hold_done) ? (take ? ACT_ON : ACT_IDLE) : // RULE10
		state_ff;
	assign nxt_hold = (nxt_state != state_ff || hold_done) ? 12'h000 :
		i_tick_ms ? phase_t'(hold_ff + 12'h001) : hold_ff;
	// frame set wins over the clear when a new phase starts
	assign nxt_pend = i_link && (i_frame || (pend_ff && !(nxt_state == ACT_ON && state_ff != ACT_ON)));

	// state registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_ff <= ACT_IDLE;
			hold_ff <= 12'h000;
			pend_ff <= 1'h0;
			lit_ff <= 1'h0;
		end else begin
			state_ff <= nxt_state;
			hold_ff <= nxt_hold;
			pend_ff <= nxt_pend;
			lit_ff <= (nxt_state == ACT_ON); // RULE9
		end
	end

	assign o_lit = lit_ff;

endmodule

/* tb/network_status_led_patterns_props.sv */
// concurrent checks on the led pattern block ports
`timescale 1ns/1ns
module network_status_led_patterns_props #(
	parameter int P_PORTS = 2,
	parameter int P_TICK_CYCLES = net_led_pkg::TICK_CYCLES
) (
	// clock and reset
	input logic i_clk_sys,
	input logic i_rst_n,
	// state inputs
	input logic i_profile,
	input logic i_task_ready,
	input logic i_task_configured,
	input logic i_task_connected,
	input logic i_sys_error,
	input logic i_comm_error,
	input net_led_pkg::cn_state_e i_cn_state,
	input logic i_cn_error,
	input logic [P_PORTS-1:0] i_link,
	input logic [P_PORTS-1:0] i_frame,
	// led outputs
	input logic o_status_green,
	input logic o_status_red,
	input logic o_fault_red,
	input logic [P_PORTS-1:0] o_port_green,
	input logic [P_PORTS-1:0] o_port_yellow
);
	import net_led_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// ==================================================================
	// profile and state decode
	wire tcp = i_profile == PROFILE_TCP;
	wire node = i_profile == PROFILE_CN;
	wire alt = node && (i_cn_state == CN_BASIC_ETH || i_cn_state == CN_STOPPED);
	// a condition held over the two-cycle pattern latency
	sequence held(x);
		x ##1 x;
	endsequence
	// ==================================================================
	// output relations
	reset_dark_a: assert property (disable iff (1'b0) !i_rst_n |=> !o_status_green && !o_status_red
		&& !o_fault_red && o_port_green == '0 && o_port_yellow == '0) else $error("led lit after reset");
	tcp_dark_a: assert property (held(tcp && !i_task_ready) |=> !o_status_green) else $error("run lit");
	tcp_steady_a: assert property (held(tcp && i_task_ready && i_task_connected) |=> o_status_green)
		else $error("run not steady");
	tcp_red_a: assert property (held(tcp) |=> !o_status_red) else $error("run red lit");
	comm_err_a: assert property (held(tcp && i_comm_error) |=> o_fault_red) else $error("error dark");
	no_err_a: assert property (held(tcp && !i_comm_error && !i_sys_error) |=> !o_fault_red)
		else $error("error lit");
	tcp_link_a: assert property (held(tcp && i_link[0]) |=> o_port_green[0]) else $error("link dark");
	no_link_a: assert property (held(!i_link[0]) |=> !o_port_green[0] && !o_port_yellow[0])
		else $error("port lit without link");
	node_yellow_a: assert property (held(node) |=> o_port_yellow == '0) else $error("yellow lit");
	node_fault_a: assert property (held(node && i_cn_error) |=> o_fault_red) else $error("fault dark");
	node_clear_a: assert property (held(node && !i_cn_error) |=> !o_fault_red) else $error("fault lit");
	node_oper_a: assert property (held(node && i_cn_state == CN_OPER) |=> o_status_green && !o_status_red)
		else $error("oper not steady");
	node_init_a: assert property (held(node && i_cn_state == CN_INIT) |=> !o_status_green && !o_status_red)
		else $error("init lit");
	alt_color_a: assert property (held(alt) |=> o_status_green != o_status_red)
		else $error("colours not alternating");
endmodule
bind network_status_led_patterns network_status_led_patterns_props #(.P_PORTS(P_PORTS),
	.P_TICK_CYCLES(P_TICK_CYCLES)) props_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_profile(i_profile), .i_task_ready(i_task_ready), .i_task_configured(i_task_configured),
	.i_task_connected(i_task_connected), .i_sys_error(i_sys_error), .i_comm_error(i_comm_error),
	.i_cn_state(i_cn_state), .i_cn_error(i_cn_error), .i_link(i_link), .i_frame(i_frame),
	.o_status_green(o_status_green), .o_status_red(o_status_red), .o_fault_red(o_fault_red),
	.o_port_green(o_port_green), .o_port_yellow(o_port_yellow));

/* tb/port_status_model.sv */
// link and frame source standing in for one ethernet port
`timescale 1ns/1ns
module port_status_model (
	// clock
	input logic i_clk_sys,
	// control
	input logic i_link_en,
	input logic [7:0] i_gap,
	// port status
	output logic o_link,
	output logic o_frame
);
	logic [7:0] cnt_ff = 8'h00;
	// frame spacing counter
	always_ff @(posedge i_clk_sys) begin
		cnt_ff <= (cnt_ff >= i_gap) ? 8'h00 : cnt_ff + 8'h01;
	end
	// no frames without link or with zero gap
	assign o_link = i_link_en;
	assign o_frame = i_link_en && i_gap != 8'h00 && cnt_ff == 8'h00;
endmodule

/* tb/network_status_led_patterns_tb.sv */
// self-checking bench for the led pattern block
`timescale 1ns/1ns
module network_status_led_patterns_tb;
	import net_led_pkg::*;
	localparam int TK = 5; // cycles per ms tick
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_profile = PROFILE_TCP;
	logic i_task_ready = 1'b0;
	logic i_task_configured = 1'b0;
	logic i_task_connected = 1'b0;
	logic i_sys_error = 1'b0;
	logic i_comm_error = 1'b0;
	cn_state_e i_cn_state = CN_INIT;
	logic i_cn_error = 1'b0;
	wire [1:0] i_link;
	wire [1:0] i_frame;
	logic [1:0] link_en = 2'h0;
	logic [7:0] gap0 = 8'h00;
	logic [7:0] gap1 = 8'h00;
	logic o_status_green;
	logic o_status_red;
	logic o_fault_red;
	logic [1:0] o_port_green;
	logic [1:0] o_port_yellow;
	int fail_count = 0;
	int cmp_count = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	// ==================================================================
	// design and port models
	network_status_led_patterns #(.P_PORTS(2), .P_TICK_CYCLES(TK)) network_status_led_patterns_inst (
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_profile(i_profile), .i_task_ready(i_task_ready),
		.i_task_configured(i_task_configured), .i_task_connected(i_task_connected),
		.i_sys_error(i_sys_error), .i_comm_error(i_comm_error), .i_cn_state(i_cn_state),
		.i_cn_error(i_cn_error), .i_link(i_link), .i_frame(i_frame), .o_status_green(o_status_green),
		.o_status_red(o_status_red), .o_fault_red(o_fault_red), .o_port_green(o_port_green),
		.o_port_yellow(o_port_yellow));
	port_status_model ps0_inst (.i_clk_sys(i_clk_sys), .i_link_en(link_en[0]), .i_gap(gap0),
		.o_link(i_link[0]), .o_frame(i_frame[0]));
	port_status_model ps1_inst (.i_clk_sys(i_clk_sys), .i_link_en(link_en[1]), .i_gap(gap1),
		.o_link(i_link[1]), .o_frame(i_frame[1]));
	// ==================================================================
	// helpers
	task summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task check_int(input string name, input int exp, input int got);
		cmp_count++;
		if (got != exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task check_bit(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	task do_reset(input logic prof);
		i_rst_n = 1'b0;
		i_profile = prof;
		cyc(5);
		i_rst_n = 1'b1;
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: return o_status_green;
			1: return o_fault_red;
			2: return o_port_yellow[0];
			default: return o_port_green[0];
		endcase
	endfunction
	// {known, level} of the run led for a task state
	function automatic logic [1:0] run_exp(input logic r, input logic k);
		return !r ? 2'b10 : (k ? 2'b11 : 2'b00);
	endfunction
	// skips the first lit phase, then times each following phase in ms
	task runs(input string name, input int sel, input int ms[$]);
		int n;
		logic lvl;
		n = 0;
		cyc(3);
		while (pick(sel) !== 1'b1 && n < 30000) begin cyc(1); n++; end
		while (pick(sel) !== 1'b0 && n < 30000) begin cyc(1); n++; end
		lvl = 1'b0;
		foreach (ms[i]) begin
			n = 0;
			while (pick(sel) === lvl && n < 30000) begin cyc(1); n++; end
			check_int(name, ms[i] * TK, n);
			lvl = ~lvl;
		end
		$display("test %s done", name);
	endtask
	// ==================================================================
	// watchdog
	// clean run takes about 46k cycles; allow some margin
	initial begin
		#900000;
		fail_count++;
		summarize();
	end
	// ==================================================================
	// main sequence
	initial begin
		logic [1:0] e;
		void'($urandom(40436));
		do_reset(PROFILE_TCP);
		repeat (24) begin
			{i_task_ready, i_task_configured, i_task_connected, i_sys_error, i_comm_error} = 5'($urandom);
			link_en = 2'($urandom);
			cyc(4);
			e = run_exp(i_task_ready, i_task_connected);
			if (e[1]) check_bit("run", e[0], o_status_green);
			if (i_comm_error || !i_sys_error) check_bit("err", i_comm_error, o_fault_red);
			check_bit("link", link_en[0], o_port_green[0]);
		end
		$display("test tcp_sweep done");
		{i_task_ready, i_task_configured, i_task_connected, i_sys_error, i_comm_error} = 5'h10;
		runs("run_slow", 0, '{500, 500});
		i_task_configured = 1'b1;
		runs("run_fast", 0, '{100, 100, 100});
		i_sys_error = 1'b1;
		runs("err_flash", 1, '{375, 125});
		link_en = 2'h3;
		gap0 = 8'($urandom_range(40, 1));
		gap1 = 8'($urandom_range(40, 1));
		runs("act_heavy", 2, '{50, 50, 50});
		gap0 = 8'h00;
		cyc(210 * TK);
		check_bit("act_idle", 1'b0, o_port_yellow[0]);
		$display("test act_idle done");
		do_reset(PROFILE_CN);
		i_cn_state = CN_READY;
		runs("triple", 0, '{200, 200, 200, 200, 1000});
		i_cn_state = CN_PREOP2;
		runs("double", 0, '{200, 200, 1000});
		i_cn_state = CN_PREOP1;
		runs("single", 0, '{1000, 200});
		// green is dark here; a restarted pattern must open with its lit phase
		i_cn_state = CN_BASIC_ETH;
		cyc(3);
		check_bit("restart", 1'b1, o_status_green);
		runs("flicker", 0, '{50, 50, 50});
		i_cn_state = CN_STOPPED;
		runs("blink", 0, '{200, 200});
		// green has just ended its phase, so red takes over
		check_bit("blink_red", 1'b1, o_status_red);
		i_cn_state = CN_OPER;
		i_cn_error = 1'b1;
		cyc(4);
		check_bit("oper", 1'b1, o_status_green);
		check_bit("fault", 1'b1, o_fault_red);
		i_cn_state = CN_INIT;
		link_en = 2'h3;
		gap1 = 8'h00;
		cyc(210 * TK);
		check_bit("init", 1'b0, o_status_green);
		check_bit("node_link", 1'b1, o_port_green[0]);
		check_bit("node_yellow", 1'b0, o_port_yellow[1]);
		$display("test node_static done");
		gap0 = 8'($urandom_range(40, 1));
		// let the first, shortened on phase pass before timing
		cyc(60 * TK);
		runs("node_act", 3, '{50, 50});
		summarize();
	end
endmodule
